// ==== tcpwm_defines.svh ====
`ifndef TCPWM_DEFINES_SVH
`define TCPWM_DEFINES_SVH

// Register addresses on the special-function bus
`define TCPWM_ADDR_INT_EN 8'hA9
`define TCPWM_ADDR_INT_PRI 8'hB9
`define TCPWM_ADDR_CFG 8'hD1
`define TCPWM_ADDR_CTRL 8'hD2
`define TCPWM_ADDR_PRD 8'hD3
`define TCPWM_ADDR_DITH 8'hD4
`define TCPWM_ADDR_W0 8'hD5
`define TCPWM_ADDR_W1 8'hD6
`define TCPWM_ADDR_W2 8'hD7

// Field positions
`define TCPWM_INT_EN_BIT 1
`define TCPWM_INT_PRI_BIT 1
`define TCPWM_CTRL_RUN 7
`define TCPWM_CTRL_FLAG 6
`define TCPWM_CTRL_ROUTE_LSB 3
`define TCPWM_CFG_INV_LSB 3
`define TCPWM_DITH_CH0_LSB 0
`define TCPWM_DITH_CH1_LSB 2
`define TCPWM_DITH_CH2_LSB 4

// Writable bit masks; bits outside read as zero, except CTRL bit 6, which reads the flag
`define TCPWM_INT_EN_MASK 8'h0E
`define TCPWM_INT_PRI_MASK 8'h0E
`define TCPWM_CTRL_MASK 8'hBF
`define TCPWM_CFG_MASK 8'hFF
`define TCPWM_DITH_MASK 8'h3F

// Reset values
`define TCPWM_RST_BYTE 8'h00

`endif

// ==== tcpwm_pkg.sv ====
package tcpwm_pkg;
  typedef logic [7:0] tcpwm_byte_t;
  typedef logic [1:0] tcpwm_dither_t;
  typedef logic [8:0] tcpwm_wide_t;

  // High width including the dither clock for this period of the group
  function automatic tcpwm_wide_t eff_width(input tcpwm_byte_t w, input tcpwm_dither_t d,
                                            input tcpwm_dither_t idx);
    eff_width = {1'b0, w} + {8'h00, (idx < d)};
  endfunction
endpackage

// ==== tcpwm_period_counter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tcpwm_defines.svh"
module tcpwm_period_counter (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_clk_en, // Freezes state when low
  input wire logic i_tick, // Prescaled modulator clock pulse
  input wire logic i_run, // Module running
  input wire tcpwm_pkg::tcpwm_byte_t i_prd, // Programmed period value
  output tcpwm_pkg::tcpwm_byte_t o_cnt, // Shared count
  output tcpwm_pkg::tcpwm_byte_t o_prd_act, // Period in force
  output logic o_wrap // Pulse: last count of a period
);
  tcpwm_pkg::tcpwm_byte_t cnt_r;
  tcpwm_pkg::tcpwm_byte_t prd_r;
  wire logic at_top = (cnt_r == prd_r);

  // Wrap only counts while running, so no overflow with module off
  assign o_wrap = i_clk_en & i_run & i_tick & at_top;
  assign o_cnt = cnt_r;
  assign o_prd_act = prd_r;

  // Period reloads at the wrap so a new value never cuts a period short
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= `TCPWM_RST_BYTE;
      prd_r <= `TCPWM_RST_BYTE;
    end else if (i_clk_en) begin
      if (!i_run) begin
        cnt_r <= `TCPWM_RST_BYTE;
        prd_r <= i_prd;
      end else if (i_tick && at_top) begin
        cnt_r <= `TCPWM_RST_BYTE;
        prd_r <= i_prd;
      end else if (i_tick) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tcpwm_channel.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tcpwm_defines.svh"
module tcpwm_channel (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_clk_en, // Freezes state when low
  input wire logic i_run, // Module running
  input wire logic i_wrap, // Period end pulse
  input wire tcpwm_pkg::tcpwm_byte_t i_cnt, // Shared count
  input wire tcpwm_pkg::tcpwm_byte_t i_width, // Programmed high width
  input wire tcpwm_pkg::tcpwm_dither_t i_dither, // Dither field
  input wire logic i_inv, // Polarity flip
  output logic o_wave // Registered waveform
);
  tcpwm_pkg::tcpwm_byte_t width_r;
  tcpwm_pkg::tcpwm_dither_t dith_r;
  tcpwm_pkg::tcpwm_dither_t idx_r;
  logic wave_r;
  tcpwm_pkg::tcpwm_wide_t eff;
  wire logic high_now;

  // Dither adds one clock in the first N periods of the group
  assign eff = tcpwm_pkg::eff_width(width_r, dith_r, idx_r);
  // Zero width stays low, width past the period stays high
  assign high_now = i_run & ({1'b0, i_cnt} < eff);
  assign o_wave = wave_r;

  // Settings latch at the wrap or while stopped; index steps through four periods
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      width_r <= `TCPWM_RST_BYTE;
      dith_r <= 2'h0;
      idx_r <= 2'h0;
      wave_r <= 1'b0;
    end else if (i_clk_en) begin
      wave_r <= high_now ^ i_inv;
      if (!i_run || i_wrap) begin
        width_r <= i_width;
        dith_r <= i_dither;
      end
      if (!i_run) begin
        idx_r <= 2'h0;
      end else if (i_wrap) begin
        idx_r <= idx_r + 2'h1;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  property p_width_stable;
    i_clk_en && i_run && !i_wrap |=> $stable(width_r);
  endproperty
  a_width_stable: assert property (p_width_stable) else $error("width changed mid period");

  property p_idx_step;
    i_wrap |=> idx_r == $past(idx_r) + 2'h1;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("period index did not advance");

  property p_dither_zero;
    i_clk_en && dith_r == 2'h0 |-> eff == {1'b0, width_r};
  endproperty
  a_dither_zero: assert property (p_dither_zero) else $error("dither zero added a clock");

  property p_dither_first;
    i_clk_en && dith_r != 2'h0 && idx_r == 2'h0 |-> eff == {1'b0, width_r} + 9'h001;
  endproperty
  a_dither_first: assert property (p_dither_first) else $error("first period not lengthened");

  property p_dither_last;
    i_clk_en && idx_r == 2'h3 |-> eff == {1'b0, width_r};
  endproperty
  a_dither_last: assert property (p_dither_last) else $error("fourth period lengthened");

  property p_zero_low;
    i_clk_en && i_run && eff == 9'h000 |=> o_wave == $past(i_inv);
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero width not low");
endmodule
`default_nettype wire

// ==== tcpwm_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tcpwm_defines.svh"

// Contract
// - Channel 0 high for its width setting
// - Channel 1 high for its width setting
// - Channel 2 high for its width setting
// - Channel 0 dither in bits 1..0
// - Channel 1 dither in bits 3..2
// - Channel 2 dither in bits 5..4
// - Dither zero adds no clock
// - Dither N lengthens first N periods
// - Overflow interrupt only when enable set
// - Priority bit selects high or low
// - Run enable gates counting and overflow
// - Per-channel route: waveform or port pin
// - Routes off still runs 8-bit timer
// - One counter, one shared interrupt
// - Count to period then zero
// - Hardware sets flag, software clears it
// - New width and period next period
// - Per-channel output polarity flip
module tcpwm_top (
  input wire logic i_sys_clk, // System clock, 250 MHz
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_clk_en, // Freezes all state when low
  input wire logic i_mod_tick, // Prescaled modulator clock pulse
  input wire logic [7:0] i_sfr_addr, // Register address
  input wire logic [7:0] i_sfr_wdata, // Write data
  input wire logic i_sfr_wr, // Write strobe
  input wire logic i_sfr_rd, // Read strobe
  input wire logic [2:0] i_gpio_out, // Port data for the shared pins
  output tcpwm_pkg::tcpwm_byte_t o_sfr_rdata, // Registered read data
  output logic [2:0] o_pin_out, // Level driven to the shared pins
  output logic [2:0] o_pin_route, // High where a pin carries a waveform
  output logic o_irq_req, // Shared modulator interrupt request
  output logic o_irq_high_prio // High priority selected
);
  // Register storage
  tcpwm_pkg::tcpwm_byte_t int_en_r;
  tcpwm_pkg::tcpwm_byte_t int_pri_r;
  tcpwm_pkg::tcpwm_byte_t cfg_r;
  tcpwm_pkg::tcpwm_byte_t ctrl_r;
  tcpwm_pkg::tcpwm_byte_t prd_r;
  tcpwm_pkg::tcpwm_byte_t dith_r;
  tcpwm_pkg::tcpwm_byte_t width0_r;
  tcpwm_pkg::tcpwm_byte_t width1_r;
  tcpwm_pkg::tcpwm_byte_t width2_r;
  logic flag_r;
  tcpwm_pkg::tcpwm_byte_t rdata_r;
  logic [2:0] pin_r;

  // Counter and channel wiring
  tcpwm_pkg::tcpwm_byte_t cnt;
  tcpwm_pkg::tcpwm_byte_t prd_act;
  logic wrap;
  logic [2:0] wave;

  // Address decode
  wire logic hit_int_en = (i_sfr_addr == `TCPWM_ADDR_INT_EN);
  wire logic hit_int_pri = (i_sfr_addr == `TCPWM_ADDR_INT_PRI);
  wire logic hit_cfg = (i_sfr_addr == `TCPWM_ADDR_CFG);
  wire logic hit_ctrl = (i_sfr_addr == `TCPWM_ADDR_CTRL);
  wire logic hit_prd = (i_sfr_addr == `TCPWM_ADDR_PRD);
  wire logic hit_dith = (i_sfr_addr == `TCPWM_ADDR_DITH);
  wire logic hit_w0 = (i_sfr_addr == `TCPWM_ADDR_W0);
  wire logic hit_w1 = (i_sfr_addr == `TCPWM_ADDR_W1);
  wire logic hit_w2 = (i_sfr_addr == `TCPWM_ADDR_W2);
  wire logic wr_ctrl = i_sfr_wr & hit_ctrl;

  // Named controls pulled from the registers
  wire logic modulator_run_enable = ctrl_r[`TCPWM_CTRL_RUN];
  wire logic [2:0] channel_pin_route_enable = ctrl_r[`TCPWM_CTRL_ROUTE_LSB +: 3];
  wire logic modulator_irq_enable = int_en_r[`TCPWM_INT_EN_BIT];
  wire logic modulator_irq_priority = int_pri_r[`TCPWM_INT_PRI_BIT];
  wire logic ch0_polarity_flip = cfg_r[`TCPWM_CFG_INV_LSB];
  wire logic ch1_polarity_flip = cfg_r[`TCPWM_CFG_INV_LSB + 1];
  wire logic ch2_polarity_flip = cfg_r[`TCPWM_CFG_INV_LSB + 2];
  wire tcpwm_pkg::tcpwm_dither_t ch0_dither_value = dith_r[`TCPWM_DITH_CH0_LSB +: 2];
  wire tcpwm_pkg::tcpwm_dither_t ch1_dither_value = dith_r[`TCPWM_DITH_CH1_LSB +: 2];
  wire tcpwm_pkg::tcpwm_dither_t ch2_dither_value = dith_r[`TCPWM_DITH_CH2_LSB +: 2];

  // Flag clear only by writing zero; a wrap in the same cycle still wins
  wire logic flag_clr = wr_ctrl & ~i_sfr_wdata[`TCPWM_CTRL_FLAG];
  wire logic flag_nxt = wrap | (flag_r & ~flag_clr);

  // Read mux; unmapped addresses and reserved bits read zero
  tcpwm_pkg::tcpwm_byte_t rd_mux;
  assign rd_mux = ({8{hit_int_en}} & int_en_r) |
                  ({8{hit_int_pri}} & int_pri_r) |
                  ({8{hit_cfg}} & cfg_r) |
                  ({8{hit_ctrl}} & (ctrl_r | {1'b0, flag_r, 6'h00})) |
                  ({8{hit_prd}} & prd_r) |
                  ({8{hit_dith}} & dith_r) |
                  ({8{hit_w0}} & width0_r) |
                  ({8{hit_w1}} & width1_r) |
                  ({8{hit_w2}} & width2_r);

  // Pin mux: routed channels carry the waveform, others follow the port
  wire logic [2:0] pin_nxt = (channel_pin_route_enable & wave) |
                             (~channel_pin_route_enable & i_gpio_out);

  // Interrupt ties to the one shared flag, never to any route bit
  assign o_irq_req = flag_r & modulator_irq_enable;
  assign o_irq_high_prio = modulator_irq_priority;
  assign o_sfr_rdata = rdata_r;
  assign o_pin_out = pin_r;
  assign o_pin_route = channel_pin_route_enable;

  // Register writes; each keeps only its implemented bits
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_en_r <= `TCPWM_RST_BYTE;
      int_pri_r <= `TCPWM_RST_BYTE;
      cfg_r <= `TCPWM_RST_BYTE;
      ctrl_r <= `TCPWM_RST_BYTE;
      prd_r <= `TCPWM_RST_BYTE;
      dith_r <= `TCPWM_RST_BYTE;
    end else if (i_clk_en && i_sfr_wr) begin
      if (hit_int_en) begin
        int_en_r <= i_sfr_wdata & `TCPWM_INT_EN_MASK;
      end
      if (hit_int_pri) begin
        int_pri_r <= i_sfr_wdata & `TCPWM_INT_PRI_MASK;
      end
      if (hit_cfg) begin
        cfg_r <= i_sfr_wdata & `TCPWM_CFG_MASK;
      end
      if (hit_ctrl) begin
        ctrl_r <= i_sfr_wdata & `TCPWM_CTRL_MASK;
      end
      if (hit_prd) begin
        prd_r <= i_sfr_wdata;
      end
      if (hit_dith) begin
        dith_r <= i_sfr_wdata & `TCPWM_DITH_MASK;
      end
    end
  end

  // Width settings; the channels take them only at the period end or while stopped
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      width0_r <= `TCPWM_RST_BYTE;
      width1_r <= `TCPWM_RST_BYTE;
      width2_r <= `TCPWM_RST_BYTE;
    end else if (i_clk_en && i_sfr_wr) begin
      if (hit_w0) begin
        width0_r <= i_sfr_wdata;
      end
      if (hit_w1) begin
        width1_r <= i_sfr_wdata;
      end
      if (hit_w2) begin
        width2_r <= i_sfr_wdata;
      end
    end
  end

  // Overflow flag, read data and pin levels
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flag_r <= 1'b0;
      rdata_r <= `TCPWM_RST_BYTE;
      pin_r <= 3'h0;
    end else if (i_clk_en) begin
      flag_r <= flag_nxt;
      pin_r <= pin_nxt;
      if (i_sfr_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // One period counter serves all three channels
  tcpwm_period_counter u_counter (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_tick(i_mod_tick),
    .i_run(modulator_run_enable),
    .i_prd(prd_r),
    .o_cnt(cnt),
    .o_prd_act(prd_act),
    .o_wrap(wrap)
  );

  tcpwm_channel u_ch0 (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_run(modulator_run_enable),
    .i_wrap(wrap),
    .i_cnt(cnt),
    .i_width(width0_r),
    .i_dither(ch0_dither_value),
    .i_inv(ch0_polarity_flip),
    .o_wave(wave[0])
  );

  tcpwm_channel u_ch1 (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_run(modulator_run_enable),
    .i_wrap(wrap),
    .i_cnt(cnt),
    .i_width(width1_r),
    .i_dither(ch1_dither_value),
    .i_inv(ch1_polarity_flip),
    .o_wave(wave[1])
  );

  tcpwm_channel u_ch2 (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_run(modulator_run_enable),
    .i_wrap(wrap),
    .i_cnt(cnt),
    .i_width(width2_r),
    .i_dither(ch2_dither_value),
    .i_inv(ch2_polarity_flip),
    .o_wave(wave[2])
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // Wrap then flag set, and it stays until a clearing write
  sequence s_wrap;
    wrap;
  endsequence

  sequence s_flag_held;
    flag_r [*2];
  endsequence

  property p_flag_set;
    s_wrap |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

  property p_flag_sticky;
    i_clk_en && flag_r && !wr_ctrl |=> flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

  property p_flag_set_wins;
    i_clk_en && wrap && flag_clr |=> s_flag_held or flag_r;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("wrap lost to clear");

  property p_irq_gate;
    flag_r && !modulator_irq_enable |-> !o_irq_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");

  property p_irq_timer;
    i_clk_en && wrap && modulator_irq_enable && channel_pin_route_enable == 3'h0 &&
      !i_sfr_wr |=> o_irq_req;
  endproperty
  a_irq_timer: assert property (p_irq_timer) else $error("timer overflow gave no request");

  property p_prio_write;
    i_clk_en && i_sfr_wr && hit_int_pri |=>
      o_irq_high_prio == $past(i_sfr_wdata[`TCPWM_INT_PRI_BIT]);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority bit not applied");

  property p_run_off;
    i_clk_en && !modulator_run_enable |-> !wrap ##1 cnt == 8'h00;
  endproperty
  a_run_off: assert property (p_run_off) else $error("counting while stopped");

  property p_wrap_zero;
    i_clk_en && modulator_run_enable && i_mod_tick && cnt == prd_act && !i_sfr_wr
      |=> cnt == 8'h00;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not return to zero");

  property p_count_up;
    i_clk_en && modulator_run_enable && i_mod_tick && cnt != prd_act && !i_sfr_wr
      |=> cnt == $past(cnt) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step");

  property p_prd_hold;
    i_clk_en && modulator_run_enable && !wrap |=> $stable(prd_act);
  endproperty
  a_prd_hold: assert property (p_prd_hold) else $error("period changed mid period");

  property p_route_pin;
    i_clk_en && channel_pin_route_enable[0] && !i_sfr_wr |=> o_pin_out[0] == $past(wave[0]);
  endproperty
  a_route_pin: assert property (p_route_pin) else $error("routed pin not waveform");

  property p_gpio_pin;
    i_clk_en && !channel_pin_route_enable[1] && !i_sfr_wr |=>
      o_pin_out[1] == $past(i_gpio_out[1]);
  endproperty
  a_gpio_pin: assert property (p_gpio_pin) else $error("unrouted pin not port data");

  // Same pin rules on the other channels
  property p_route_pin1;
    i_clk_en && channel_pin_route_enable[1] |=> o_pin_out[1] == $past(wave[1]);
  endproperty
  a_route_pin1: assert property (p_route_pin1) else $error("routed pin 1 not waveform");

  property p_route_pin2;
    i_clk_en && channel_pin_route_enable[2] |=> o_pin_out[2] == $past(wave[2]);
  endproperty
  a_route_pin2: assert property (p_route_pin2) else $error("routed pin 2 not waveform");

  property p_gpio_pin0;
    i_clk_en && !channel_pin_route_enable[0] |=> o_pin_out[0] == $past(i_gpio_out[0]);
  endproperty
  a_gpio_pin0: assert property (p_gpio_pin0) else $error("unrouted pin 0 not port data");

  property p_gpio_pin2;
    i_clk_en && !channel_pin_route_enable[2] |=> o_pin_out[2] == $past(i_gpio_out[2]);
  endproperty
  a_gpio_pin2: assert property (p_gpio_pin2) else $error("unrouted pin 2 not port data");

  // A clear with no wrap beside it drops the flag at once
  sequence s_clear_only;
    i_clk_en && flag_clr && !wrap;
  endsequence

  property p_flag_clear;
    s_clear_only |=> !flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag survived a clear");

  // Wrap only on a tick at the top count of a running counter
  property p_wrap_cause;
    wrap |-> i_mod_tick && modulator_run_enable && cnt == prd_act;
  endproperty
  a_wrap_cause: assert property (p_wrap_cause) else $error("wrap without top count");

  // Routes all off: the counter still wraps as a plain timer
  property p_timer_wrap;
    i_clk_en && modulator_run_enable && channel_pin_route_enable == 3'h0 && i_mod_tick &&
      cnt == prd_act |-> wrap;
  endproperty
  a_timer_wrap: assert property (p_timer_wrap) else $error("timer did not wrap");
endmodule
`default_nettype wire

// ==== tcpwm_pin_load.sv ====
`timescale 1ns/100ps
`default_nettype none
// Load on the three shared pins; logs active pulse widths and start spacing
module tcpwm_pin_load (
  input wire logic i_sys_clk, // System clock
  input wire logic [2:0] i_pin, // Pin levels
  input wire logic [2:0] i_act_lvl, // Level the load treats as active
  input wire logic i_clear // Drop logs, restart timing
);
  int hq[3][$];
  int pq[3][$];
  int run_len[3];
  int since[3];
  bit prev[3];
  bit armed[3];

  // Lengths in system clocks; the first start only arms the period timer
  always @(posedge i_sys_clk) begin
    for (int c = 0; c < 3; c++) begin
      if (i_clear) begin
        hq[c].delete();
        pq[c].delete();
        prev[c] = 1'b0;
        armed[c] = 1'b0;
        since[c] = 0;
        run_len[c] = 0;
      end else if (i_pin[c] === i_act_lvl[c]) begin
        if (!prev[c]) begin
          if (armed[c]) begin
            pq[c].push_back(since[c]);
          end
          armed[c] = 1'b1;
          since[c] = 0;
          run_len[c] = 0;
        end
        run_len[c]++;
        since[c]++;
        prev[c] = 1'b1;
      end else begin
        // Unknown levels count as inactive so they never pass for a pulse
        if (prev[c]) begin
          hq[c].push_back(run_len[c]);
        end
        since[c]++;
        prev[c] = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tcpwm_defines.svh"
module tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_mod_tick = 1'b1;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [2:0] i_gpio_out = 3'h0;
  logic [7:0] o_sfr_rdata;
  logic [2:0] o_pin_out;
  logic [2:0] o_pin_route;
  logic o_irq_req;
  logic o_irq_high_prio;
  logic [2:0] act_lvl = 3'h7;
  logic ld_clear = 1'b0;
  logic tick_ph = 1'b0;
  int tick_div = 1;
  int mismatches = 0;
  int tests_run = 0;

  tcpwm_top dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
    .i_mod_tick(i_mod_tick), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_gpio_out(i_gpio_out),
    .o_sfr_rdata(o_sfr_rdata), .o_pin_out(o_pin_out), .o_pin_route(o_pin_route),
    .o_irq_req(o_irq_req), .o_irq_high_prio(o_irq_high_prio)
  );

  tcpwm_pin_load load_u (
    .i_sys_clk(i_sys_clk), .i_pin(o_pin_out), .i_act_lvl(act_lvl), .i_clear(ld_clear)
  );

  // 250 MHz system clock
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // Tick every clock or every second clock; port data changes every cycle
  always @(negedge i_sys_clk) begin
    tick_ph <= ~tick_ph;
    i_mod_tick <= (tick_div == 1) | tick_ph;
    i_gpio_out <= 3'($urandom);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One idle cycle between accesses keeps each strobe a clean pulse
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_sys_clk);
    i_sfr_addr = a;
    i_sfr_wdata = v;
    i_sfr_wr = 1'b1;
    @(negedge i_sys_clk);
    i_sfr_wr = 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_sys_clk);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    @(negedge i_sys_clk);
    i_sfr_rd = 1'b0;
    check(16'(o_sfr_rdata), 16'(e));
  endtask

  // High width of period k inside its group of four
  function automatic int exp_w(input int w, input int d, input int k);
    return w + (((k % 4) < d) ? 1 : 0);
  endfunction

  // Stopped set-up, then eleven periods of all three channels with dither
  task automatic run_wave(input int it);
    logic [7:0] prd;
    logic [7:0] w[3];
    logic [1:0] d[3];
    logic [2:0] inv;
    prd = 8'(8 + $urandom_range(0, 24));
    inv = (it == 3) ? 3'b111 : 3'b000;
    tick_div = 1 + it % 2;
    bus_wr(`TCPWM_ADDR_CTRL, 8'h38);
    bus_wr(`TCPWM_ADDR_CFG, {2'b00, inv, 3'b000});
    bus_wr(`TCPWM_ADDR_PRD, prd);
    for (int c = 0; c < 3; c++) begin
      w[c] = 8'($urandom_range(1, prd - 2));
      d[c] = 2'((it + c) % 4);
      bus_wr(`TCPWM_ADDR_W0 + 8'(c), w[c]);
    end
    bus_wr(`TCPWM_ADDR_DITH, {2'b00, d[2], d[1], d[0]});
    bus_wr(`TCPWM_ADDR_INT_EN, it[0] ? 8'h00 : 8'h02);
    act_lvl = ~inv;
    @(negedge i_sys_clk);
    ld_clear = 1'b1;
    @(negedge i_sys_clk);
    ld_clear = 1'b0;
    bus_wr(`TCPWM_ADDR_CTRL, 8'hB8);
    repeat (11 * (prd + 1) * tick_div) @(negedge i_sys_clk);
    // First pulse skipped: its start depends on the tick phase
    for (int c = 0; c < 3; c++) begin
      for (int k = 1; k < 9; k++) begin
        check(16'(load_u.hq[c][k]), 16'(exp_w(w[c], d[c], k) * tick_div));
        if (k < 8) begin
          check(16'(load_u.pq[c][k]), 16'((prd + 1) * tick_div));
        end
      end
    end
    bus_rd(`TCPWM_ADDR_CTRL, 8'hF8);
    check(16'(o_irq_req), 16'(!it[0]));
    // A one in the flag bit is ignored; a zero while stopped clears it
    bus_wr(`TCPWM_ADDR_CTRL, 8'h78);
    bus_rd(`TCPWM_ADDR_CTRL, 8'h78);
    check(16'(o_irq_req), 16'(!it[0]));
    bus_wr(`TCPWM_ADDR_CTRL, 8'h38);
    bus_rd(`TCPWM_ADDR_CTRL, 8'h38);
    check(16'(o_irq_req), 16'h0000);
    repeat (60) @(negedge i_sys_clk);
    bus_rd(`TCPWM_ADDR_CTRL, 8'h38);
  endtask

  initial begin
    logic [7:0] addr[6];
    logic [7:0] mask[6];
    logic [7:0] v;
    logic [2:0] g;
    addr = '{`TCPWM_ADDR_INT_EN, `TCPWM_ADDR_INT_PRI, `TCPWM_ADDR_DITH,
             `TCPWM_ADDR_W0, `TCPWM_ADDR_W1, `TCPWM_ADDR_W2};
    mask = '{`TCPWM_INT_EN_MASK, `TCPWM_INT_PRI_MASK, `TCPWM_DITH_MASK, 8'hFF, 8'hFF, 8'hFF};
    void'($urandom(82556));
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    // Reset values, then an unmapped place that must stay empty
    for (int i = 0; i < 6; i++) begin
      bus_rd(addr[i], 8'h00);
    end
    check(16'(o_irq_high_prio), 16'h0000);
    bus_wr(8'h60, 8'hFF);
    bus_rd(8'h60, 8'h00);
    // Random register contents; priority bit toggled between rounds
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 6; i++) begin
        v = 8'($urandom);
        if (i == 1) begin
          v[1] = r[0];
        end
        bus_wr(addr[i], v);
        bus_rd(addr[i], v & mask[i]);
      end
      check(16'(o_irq_high_prio), 16'(r[0]));
    end
    for (int it = 0; it < 4; it++) begin
      run_wave(it);
    end
    // Counter alone with every pin left to the port, then channel 1 routed to its pin; tick every clock from here
    tick_div = 1;
    bus_wr(`TCPWM_ADDR_INT_EN, 8'h02);
    bus_wr(`TCPWM_ADDR_CTRL, 8'h80);
    repeat (150) @(negedge i_sys_clk);
    check(16'(o_pin_route), 16'h0000);
    check(16'(o_irq_req), 16'h0001);
    for (int n = 0; n < 20; n++) begin
      @(negedge i_sys_clk);
      check(16'(o_pin_out), 16'(i_gpio_out));
    end
    bus_rd(`TCPWM_ADDR_CTRL, 8'hC0);
    bus_wr(`TCPWM_ADDR_CTRL, 8'h90);
    repeat (3) @(negedge i_sys_clk);
    check(16'(o_pin_route), 16'h0002);
    for (int n = 0; n < 20; n++) begin
      @(negedge i_sys_clk);
      check(16'({o_pin_out[2], o_pin_out[0]}), 16'({i_gpio_out[2], i_gpio_out[0]}));
    end
    // Clock enable low freezes the pins at the last port data taken
    @(negedge i_sys_clk);
    i_clk_en = 1'b0;
    g = i_gpio_out;
    repeat (10) begin
      @(negedge i_sys_clk);
      check(16'({o_pin_out[2], o_pin_out[0]}), 16'({g[2], g[0]}));
    end
    i_clk_en = 1'b1;
    // Zero width stays low, width past the period stays high
    bus_wr(`TCPWM_ADDR_CTRL, 8'h38);
    bus_wr(`TCPWM_ADDR_CFG, 8'h00);
    bus_wr(`TCPWM_ADDR_PRD, 8'h0A);
    bus_wr(`TCPWM_ADDR_W0, 8'h00);
    bus_wr(`TCPWM_ADDR_W1, 8'hFF);
    bus_wr(`TCPWM_ADDR_DITH, 8'h00);
    bus_wr(`TCPWM_ADDR_CTRL, 8'hB8);
    repeat (5) @(negedge i_sys_clk);
    for (int n = 0; n < 40; n++) begin
      @(negedge i_sys_clk);
      check(16'(o_pin_out[1:0]), 16'h0002);
    end
    // Clearing write lands on the fifth wrap: the set wins, then a clear while stopped
    repeat (8) @(negedge i_sys_clk);
    bus_wr(`TCPWM_ADDR_CTRL, 8'h38);
    bus_rd(`TCPWM_ADDR_CTRL, 8'h78);
    bus_wr(`TCPWM_ADDR_CTRL, 8'h38);
    bus_rd(`TCPWM_ADDR_CTRL, 8'h38);
    finish_test();
  end

  // Hang guard, well past the expected run length
  initial begin
    #40000;
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
